// ### rtl/clock_source_ctrl_status_regs.sv
// control, trim and status registers of the internal clock source
//
// The implementer's own choices: the placing of the registers and register access over APB.
`include "clock_source_regs.svh"
module clock_source_ctrl_status_regs #(
  parameter int unsigned OSC_INIT_CNT = `OSC_INIT_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        debug_mode_active,
  input  wire logic                        stopMode,
  input  wire logic [7:0]                  factoryCoarseTrim,
  input  wire logic                        factoryFineTrim,
  input  wire logic                        oscillatorClockValid,
  input  wire logic                        internalRefAvailable,
  input  wire logic                        fllAvailable,
  output clock_source_pkg::analog_ctl_s    analogCtl
);
  import clock_source_pkg::*;

  // software-visible register state
  ctl2_s       ctl2_r;
  logic [7:0]  coarseTrim_r;
  logic        fineTrim_r;
  logic [1:0]  bandSel_r;
  logic        dmx_r;
  logic [1:0]  srcSel_r;
  logic        refSel_r;

  // synchroniser stages and status echoes
  logic [1:0]  bandSync1_r;
  logic [1:0]  bandSync2_r;
  logic [1:0]  bandSt_r;
  logic        refSync1_r;
  logic        refSync2_r;
  logic        refSt_r;
  logic [1:0]  srcSync1_r;
  logic [1:0]  srcSync2_r;
  logic [1:0]  modeSt_r;
  logic        ready_r;
  logic [15:0] initCnt_r;
  logic        initLoad_r;

  // oscillator and source decisions
  logic        extInUse;
  logic        oscNeeded;
  logic        oscDropped;
  logic        extReady;
  logic        srcOk;
  logic [10:0] factor;
  logic        fllOn;
  logic        bypass;
  logic        fllParked;

  // bus decode
  logic        setupPhase;
  logic        wrEn;
  logic        hitSource;
  logic        hitCtl2;
  logic        hitTrim;
  logic        hitStatus;
  logic        addrOk;
  logic        wrSource;
  logic        wrCtl2;
  logic        wrTrim;
  logic        wrStatus;
  logic [7:0]  statusByte;
  logic [31:0] rdData;

  assign setupPhase = psel && !penable;
  assign wrEn       = psel && penable && pwrite;

  // one address hit per register, one write strobe per register
  assign hitSource  = paddr == `OFF_SOURCE_SELECT;
  assign hitCtl2    = paddr == `OFF_CONTROL_TWO;
  assign hitTrim    = paddr == `OFF_PERIOD_ADJUST;
  assign hitStatus  = paddr == `OFF_STATUS_RANGE;
  assign addrOk     = hitSource || hitCtl2 || hitTrim || hitStatus;
  assign wrSource   = wrEn && hitSource;
  assign wrCtl2     = wrEn && hitCtl2;
  assign wrTrim     = wrEn && hitTrim;
  assign wrStatus   = wrEn && hitStatus;

  // control register two, divide by 2 out of reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl2_r <= ctl2_s'(`CTL2_RESET);
    end else if (wrCtl2) begin
      ctl2_r <= ctl2_s'(pwdata[7:0]);
    end
  end

  // clock source select kept at a local offset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      srcSel_r <= 2'h0;
    end else if (wrSource) begin
      srcSel_r <= (pwdata[2:1] == SRC_RSVD) ? 2'h0 : pwdata[2:1];
    end
  end

  // reference select, internal out of reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refSel_r <= 1'b1;
    end else if (wrSource) begin
      refSel_r <= pwdata[0];
    end
  end

  // marks the first cycle after reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      initLoad_r <= 1'b1;
    end else begin
      initLoad_r <= 1'b0;
    end
  end

  // coarse trim loaded after reset from factory or debug default
  always_ff @(posedge clk) begin
    if (!nrst) begin
      coarseTrim_r <= 8'h00;
    end else if (initLoad_r) begin
      coarseTrim_r <= debug_mode_active ? `TRIM_DEBUG_VALUE
                                        : factoryCoarseTrim;
    end else if (wrTrim) begin
      coarseTrim_r <= pwdata[7:0];
    end
  end

  // fine trim loaded the same way, written with the status register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fineTrim_r <= 1'b0;
    end else if (initLoad_r) begin
      fineTrim_r <= debug_mode_active ? `FINE_DEBUG_VALUE
                                      : factoryFineTrim;
    end else if (wrStatus) begin
      fineTrim_r <= pwdata[`POS_FINE];
    end
  end

  // band select, refused while powered down or for the reserved code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bandSel_r <= 2'h0;
    end else if (wrStatus && !ctl2_r.fllPowerDown &&
                 pwdata[`POS_BAND +: 2] != BAND_RSVD) begin
      bandSel_r <= pwdata[`POS_BAND +: 2];
    end
  end

  // max-frequency option, always writable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dmx_r <= 1'b0;
    end else if (wrStatus) begin
      dmx_r <= pwdata[`POS_DMX];
    end
  end

  // band echo through a two-stage synchroniser
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bandSync1_r <= 2'h0;
      bandSync2_r <= 2'h0;
      bandSt_r    <= 2'h0;
    end else begin
      bandSync1_r <= bandSel_r;
      bandSync2_r <= bandSync1_r;
      bandSt_r    <= bandSync2_r;
    end
  end

  // reference echo, internal out of reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refSync1_r <= 1'b1;
      refSync2_r <= 1'b1;
      refSt_r    <= 1'b1;
    end else begin
      refSync1_r <= refSel_r;
      refSync2_r <= refSync1_r;
      refSt_r    <= refSync2_r;
    end
  end

  // source echo; mode moves only when the new clock is there
  always_ff @(posedge clk) begin
    if (!nrst) begin
      srcSync1_r <= 2'h0;
      srcSync2_r <= 2'h0;
      modeSt_r   <= 2'h0;
    end else begin
      srcSync1_r <= srcSel_r;
      srcSync2_r <= srcSync1_r;
      if (srcOk) begin
        modeSt_r <= srcSync2_r;
      end
    end
  end

  // external clock counts as there once ready, or with no crystal asked
  assign extReady = ready_r || !ctl2_r.oscRequest;

  // new source taken only when that clock is there
  always_comb begin
    case (clk_src_e'(srcSync2_r))
      SRC_FLL:      srcOk = fllAvailable;
      SRC_INTERNAL: srcOk = internalRefAvailable;
      SRC_EXTERNAL: srcOk = extReady;
      default:      srcOk = 1'b0;
    endcase
  end

  // oscillator ready flag
  assign extInUse   = ctl2_r.extRefEnable || !refSt_r ||
                      modeSt_r == SRC_EXTERNAL;
  assign oscNeeded  = extInUse && ctl2_r.oscRequest;
  assign oscDropped = !ctl2_r.extRefEnable || !ctl2_r.oscRequest;

  // init cycle counter, restarted whenever the oscillator is not needed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      initCnt_r <= 16'h0000;
    end else if (!oscNeeded) begin
      initCnt_r <= 16'h0000;
    end else if (oscillatorClockValid && !ready_r &&
                 initCnt_r < 16'(OSC_INIT_CNT - 1)) begin
      initCnt_r <= initCnt_r + 16'h0001;
    end
  end

  // set after the init cycles, cleared when the oscillator is not needed and enable or request is clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ready_r <= 1'b0;
    end else if (!oscNeeded && oscDropped) begin
      ready_r <= 1'b0;
    end else if (oscNeeded && oscillatorClockValid &&
                 initCnt_r >= 16'(OSC_INIT_CNT - 1)) begin
      ready_r <= 1'b1;
    end
  end

  // band factor
  always_comb begin
    case (dco_band_e'(bandSt_r))
      BAND_LOW:  factor = dmx_r ? `FACTOR_LOW_32K  : `FACTOR_LOW;
      BAND_MID:  factor = dmx_r ? `FACTOR_MID_32K  : `FACTOR_MID;
      BAND_HIGH: factor = dmx_r ? `FACTOR_HIGH_32K : `FACTOR_HIGH;
      default:   factor = `FACTOR_LOW;
    endcase
  end

  // bypass modes may park the FLL unless debug needs it
  assign bypass    = modeSt_r != SRC_FLL;
  assign fllParked = bypass && ctl2_r.fllPowerDown && !debug_mode_active;
  assign fllOn     = !stopMode && !fllParked;

  // analog control outputs from flip-flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      analogCtl.extRefClockOut  <= 1'b0;
      analogCtl.extSourceEnable <= 1'b0;
      analogCtl.oscRangeHigh    <= 1'b0;
      analogCtl.oscGainHigh     <= 1'b0;
      analogCtl.oscCrystal      <= 1'b0;
      analogCtl.fllEnable       <= 1'b0;
      analogCtl.busDivSelect    <= 2'h0;
      analogCtl.clockSource     <= 2'h0;
      analogCtl.dcoBand         <= 2'h0;
      analogCtl.fllFactor       <= 11'h000;
      analogCtl.coarseTrim      <= 8'h00;
      analogCtl.fineTrim        <= 1'b0;
      analogCtl.refInternal     <= 1'b0;
    end else begin
      // oscillator side
      analogCtl.busDivSelect    <= ctl2_r.busDivider;
      analogCtl.oscRangeHigh    <= ctl2_r.rangeHigh;
      analogCtl.oscGainHigh     <= ctl2_r.gainHigh;
      analogCtl.oscCrystal      <= ctl2_r.oscRequest;
      analogCtl.extRefClockOut  <= ctl2_r.extRefEnable && !stopMode;
      analogCtl.extSourceEnable <= stopMode ?
        (ctl2_r.stopRetain && ctl2_r.extRefEnable) : extInUse;
      // fll side
      analogCtl.fllEnable       <= fllOn;
      analogCtl.clockSource     <= modeSt_r;
      analogCtl.dcoBand         <= bandSt_r;
      analogCtl.fllFactor       <= factor;
      // trims and reference
      analogCtl.coarseTrim      <= coarseTrim_r;
      analogCtl.fineTrim        <= fineTrim_r;
      analogCtl.refInternal     <= refSt_r;
    end
  end

  // status byte: echoes, option bit, ready flag, fine trim
  assign statusByte = {bandSt_r, dmx_r, refSt_r,
                       modeSt_r, ready_r, fineTrim_r};

  // read mux
  always_comb begin
    rdData = 32'h0000_0000;
    case (paddr)
      `OFF_SOURCE_SELECT: rdData[2:0] = {srcSel_r, refSel_r};
      `OFF_CONTROL_TWO:   rdData[7:0] = ctl2_r;
      `OFF_PERIOD_ADJUST: rdData[7:0] = coarseTrim_r;
      `OFF_STATUS_RANGE:  rdData[7:0] = statusByte;
      default:            rdData = 32'h0000_0000;
    endcase
  end

  // apb slave: ready in the access cycle, no further wait states
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  // error answer for an unmapped address
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPhase && !addrOk;
    end
  end

  // read data captured in the setup cycle, held through the access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= rdData;
    end
  end
endmodule : clock_source_ctrl_status_regs

// ### rtl/clock_source_pkg.sv
// types shared by the clock source control logic
package clock_source_pkg;
  typedef enum logic [1:0] {SRC_FLL, SRC_INTERNAL, SRC_EXTERNAL, SRC_RSVD}
    clk_src_e;
  typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_HIGH, BAND_RSVD}
    dco_band_e;
  typedef struct packed {
    logic [1:0] busDivider;
    logic       rangeHigh;
    logic       gainHigh;
    logic       fllPowerDown;
    logic       oscRequest;
    logic       extRefEnable;
    logic       stopRetain;
  } ctl2_s;
  typedef struct packed {
    logic       extRefClockOut;
    logic       extSourceEnable;
    logic       oscRangeHigh;
    logic       oscGainHigh;
    logic       oscCrystal;
    logic       fllEnable;
    logic [1:0] busDivSelect;
    logic [1:0] clockSource;
    logic [1:0] dcoBand;
    logic [10:0] fllFactor;
    logic [7:0] coarseTrim;
    logic       fineTrim;
    logic       refInternal;
  } analog_ctl_s;
endpackage : clock_source_pkg

// ### rtl/clock_source_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CLOCK_SOURCE_REGS_SVH
`define CLOCK_SOURCE_REGS_SVH
`define OFF_SOURCE_SELECT      12'h000
`define OFF_CONTROL_TWO        12'h004
`define OFF_PERIOD_ADJUST      12'h008
`define OFF_STATUS_RANGE       12'h00C
`define CTL2_RESET             8'h40
`define TRIM_DEBUG_VALUE       8'h80
`define FINE_DEBUG_VALUE       1'b0
`define SSEL_RESET             3'h1
`define POS_BUS_CLOCK_DIVIDER               6
`define POS_RANGE              5
`define POS_GAIN               4
`define POS_LP                 3
`define POS_OSCILLATOR_REQUEST              2
`define POS_EXTERNAL_REF_ENABLE            1
`define POS_STOPRET            0
`define POS_BAND               6
`define POS_DMX                5
`define POS_REFST              4
`define POS_MODEST             2
`define POS_READY              1
`define POS_FINE               0
`define FACTOR_LOW             11'd512
`define FACTOR_MID             11'd1024
`define FACTOR_HIGH            11'd1536
`define FACTOR_LOW_32K         11'd608
`define FACTOR_MID_32K         11'd1216
`define FACTOR_HIGH_32K        11'd1824
`define OSC_INIT_NS            20000
`define CLK_PERIOD_NS          20
`define OSC_INIT_CYCLES        ((`OSC_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### testbench/clock_source_sva.sv
// assertions on the clock source register block ports
`include "clock_source_regs.svh"
module clock_source_sva #(
  parameter int unsigned OSC_INIT_CNT = 4
) (
  input wire logic                         clk,
  input wire logic                         nrst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         debug_mode_active,
  input wire logic                         stopMode,
  input wire logic [7:0]                   factoryCoarseTrim,
  input wire logic                         factoryFineTrim,
  input wire logic                         oscillatorClockValid,
  input wire logic                         internalRefAvailable,
  input wire logic                         fllAvailable,
  input wire clock_source_pkg::analog_ctl_s analogCtl
);
  import clock_source_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctl2_wr;
    psel && penable && pready && pwrite && paddr == `OFF_CONTROL_TWO;
  endsequence
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (psel && penable && pready
    && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctl2_div: assert property (s_ctl2_wr
    |-> ##2 analogCtl.busDivSelect == $past(pwdata[7:6], 2))
    else $error("bus divider not applied");
  a_ctl2_osc: assert property ((s_ctl2_wr and !stopMode)
    |-> ##2 {analogCtl.oscRangeHigh, analogCtl.oscGainHigh,
    analogCtl.oscCrystal, analogCtl.extRefClockOut}
    == $past({pwdata[5:4], pwdata[2:1]}, 2))
    else $error("oscillator controls not applied");
  a_trim_load: assert property (!$past(nrst) |-> ##[1:2]
    analogCtl.coarseTrim == (debug_mode_active ? `TRIM_DEBUG_VALUE
    : factoryCoarseTrim) && analogCtl.fineTrim == (debug_mode_active
    ? `FINE_DEBUG_VALUE : factoryFineTrim))
    else $error("trim not loaded at reset");
  a_factor_map: assert property ($past(nrst, 2) |->
    (analogCtl.dcoBand == BAND_LOW && analogCtl.fllFactor inside
    {`FACTOR_LOW, `FACTOR_LOW_32K}) || (analogCtl.dcoBand == BAND_MID
    && analogCtl.fllFactor inside {`FACTOR_MID, `FACTOR_MID_32K})
    || (analogCtl.dcoBand == BAND_HIGH && analogCtl.fllFactor inside
    {`FACTOR_HIGH, `FACTOR_HIGH_32K}))
    else $error("factor does not match band");
  a_src_avail: assert property ($changed(analogCtl.clockSource)
    && analogCtl.clockSource == SRC_INTERNAL |-> $past(internalRefAvailable))
    else $error("switched to unavailable source");
endmodule : clock_source_sva
bind clock_source_ctrl_status_regs clock_source_sva #(
  .OSC_INIT_CNT(OSC_INIT_CNT)
) u_sva (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .debug_mode_active(debug_mode_active),
  .stopMode(stopMode), .factoryCoarseTrim(factoryCoarseTrim),
  .factoryFineTrim(factoryFineTrim), .fllAvailable(fllAvailable),
  .oscillatorClockValid(oscillatorClockValid),
  .internalRefAvailable(internalRefAvailable), .analogCtl(analogCtl)
);

// ### testbench/testbench.sv
// self-checking bench for the clock source register block
`include "clock_source_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import clock_source_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dbg = 1'b0;
  logic        stopMode = 1'b0;
  logic        oscValid = 1'b0;
  logic        irefAvail = 1'b0;
  analog_ctl_s ctl;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  d;
  logic [10:0] fac [6] = '{`FACTOR_LOW, `FACTOR_LOW_32K, `FACTOR_MID,
                           `FACTOR_MID_32K, `FACTOR_HIGH, `FACTOR_HIGH_32K};
  int          mismatches = 0;
  int          checks = 0;
  always #10 clk = ~clk;
  clock_source_ctrl_status_regs #(.OSC_INIT_CNT(4)) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_mode_active(dbg), .stopMode(stopMode),
    .factoryCoarseTrim(8'hA5), .factoryFineTrim(1'b1), .fllAvailable(1'b1),
    .oscillatorClockValid(oscValid), .internalRefAvailable(irefAvail),
    .analogCtl(ctl));
  task automatic check(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input string nm, input logic [11:0] a, logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(nm, {24'h0, e}, rd);
  endtask : rchk
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("ctl2", `OFF_CONTROL_TWO, `CTL2_RESET);
    rchk("source", `OFF_SOURCE_SELECT, 8'h01);
    rchk("trim", `OFF_PERIOD_ADJUST, 8'hA5);
    rchk("status", `OFF_STATUS_RANGE, 8'h11);
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[0], i[1], 1'b0, i[0], i[1], 1'b0};
      xfer(1'b1, `OFF_CONTROL_TWO, d);
      repeat (2) @(posedge clk);
      check("divider", 32'(i[1:0]), 32'(ctl.busDivSelect));
      check("osc", 32'({d[5:4], d[2:1]}), 32'({ctl.oscRangeHigh,
        ctl.oscGainHigh, ctl.oscCrystal, ctl.extRefClockOut}));
    end
    for (int j = 0; j < 2; j++) begin
      xfer(1'b1, `OFF_CONTROL_TWO, 8'h46 | 8'(j));
      @(posedge clk) stopMode <= 1'b1;
      repeat (3) @(posedge clk);
      check("stop source", 32'(j), 32'(ctl.extSourceEnable));
      @(posedge clk) stopMode <= 1'b0;
    end
    @(posedge clk) oscValid <= 1'b1;
    repeat (12) @(posedge clk);
    rchk("ready set", `OFF_STATUS_RANGE, 8'h13);
    xfer(1'b1, `OFF_CONTROL_TWO, 8'h44);
    repeat (3) @(posedge clk);
    rchk("ready clear", `OFF_STATUS_RANGE, 8'h11);
    for (int k = 0; k < 6; k++) begin
      d = {2'(k / 2), 1'(k % 2), 5'h01};
      xfer(1'b1, `OFF_STATUS_RANGE, d);
      repeat (4) @(posedge clk);
      rchk("band", `OFF_STATUS_RANGE, d | 8'h10);
      check("factor", 32'(fac[k]), 32'(ctl.fllFactor));
    end
    xfer(1'b1, `OFF_STATUS_RANGE, 8'hC1);
    repeat (4) @(posedge clk);
    rchk("reserved band", `OFF_STATUS_RANGE, 8'h91);
    xfer(1'b1, `OFF_CONTROL_TWO, 8'h48);
    xfer(1'b1, `OFF_STATUS_RANGE, 8'h21);
    xfer(1'b1, `OFF_SOURCE_SELECT, 8'h03);
    repeat (5) @(posedge clk);
    rchk("low power band", `OFF_STATUS_RANGE, 8'hB1);
    @(posedge clk) irefAvail <= 1'b1;
    repeat (5) @(posedge clk);
    rchk("internal mode", `OFF_STATUS_RANGE, 8'hB5);
    check("fll off", 32'h0, 32'(ctl.fllEnable));
    @(posedge clk) dbg <= 1'b1;
    repeat (3) @(posedge clk);
    check("fll debug", 32'h1, 32'(ctl.fllEnable));
    @(posedge clk) dbg <= 1'b0;
    xfer(1'b1, `OFF_CONTROL_TWO, 8'h44);
    repeat (3) @(posedge clk);
    check("fll on", 32'h1, 32'(ctl.fllEnable));
    xfer(1'b1, `OFF_SOURCE_SELECT, 8'h04);
    repeat (12) @(posedge clk);
    rchk("external mode", `OFF_STATUS_RANGE, 8'hAB);
    xfer(1'b1, `OFF_PERIOD_ADJUST, 8'h5A);
    rchk("trim write", `OFF_PERIOD_ADJUST, 8'h5A);
    check("coarse out", 32'h5A, 32'(ctl.coarseTrim));
    xfer(1'b1, `OFF_STATUS_RANGE, 8'hA0);
    repeat (2) @(posedge clk);
    check("fine out", 32'h0, 32'(ctl.fineTrim));
    xfer(1'b0, 12'h010, 8'h00);
    check("unmapped", 32'h1, 32'({rd, err}));
    dbg <= 1'b1;
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("debug trim", `OFF_PERIOD_ADJUST, `TRIM_DEBUG_VALUE);
    rchk("debug fine", `OFF_STATUS_RANGE, 8'h10);
    print_verdict();
  end
endmodule : testbench
